/* hdl/dsr_pkg.sv */
// Shared constants and types for the dual sweep and continuous recorder.
package dsr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_GAP_US = 2500;
  localparam int unsigned MIN_GAP_CYCLES = MIN_GAP_US * US_CYCLES;
  localparam int unsigned DELAY_MAX_S = 1000;
  localparam logic [29:0] DELAY_MAX_US = 30'(DELAY_MAX_S * 1000000);
  localparam logic [17:0] MAX_SWEEPS = 18'h30D40;
  localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);

  localparam int SMP_W = 16;
  localparam int SW_AW = 10;
  localparam int SW_PW = 11;
  localparam logic [10:0] SW_DEPTH = 11'h400;
  localparam int CF_AW = 6;
  localparam int CF_PW = 7;
  localparam logic [6:0] CF_DEPTH = 7'h40;
  localparam logic [6:0] CF_HALF = 7'h20;
  localparam logic [6:0] CF_3Q = 7'h30;
  localparam logic [2:0] Q_DEPTH = 3'h4;

  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SWEEP_LEN = 5'h04;
  localparam logic [4:0] OFS_PRE_LEN = 5'h08;
  localparam logic [4:0] OFS_DELAY = 5'h0C;
  localparam logic [4:0] OFS_DURATION = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_SWEEP_CNT = 5'h18;
  localparam logic [4:0] OFS_MARK_CNT = 5'h1C;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_STRETCH = 1;
  localparam int CTRL_DELAY = 2;
  localparam int CTRL_DURATION = 3;

  localparam int ST_RECORDING = 0;
  localparam int ST_CAPTURING = 1;
  localparam int ST_SUSPENDED = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_CONT_EMPTY = 4;
  localparam int ST_SWEEP_EMPTY = 5;

  localparam logic [10:0] SWEEP_LEN_RST = 11'h400;
  localparam logic [10:0] PRE_LEN_RST = 11'h000;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ARM = 2'b01,
    PH_DELAY = 2'b10,
    PH_POST = 2'b11
  } dsr_phase_type;

  typedef enum logic [1:0] {
    K_CONT = 2'b00,
    K_SWEEP = 2'b01,
    K_MARK = 2'b10,
    K_NOTE = 2'b11
  } dsr_kind_type;

  typedef struct packed {
    dsr_kind_type kind;
    logic [SMP_W-1:0] data;
  } dsr_rec_type;

  typedef struct packed {
    logic [SW_PW-1:0] start;
    logic [SW_PW-1:0] stop;
  } dsr_span_type;
endpackage : dsr_pkg

/* hdl/dsr_interval_guard.sv */
// Minimum interval guard: after each event it stays busy for a fixed number of cycles.
`timescale 1ns/1ns
module dsr_interval_guard #(
  parameter logic [17:0] COUNT = 18'h3D090
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic ready
);
  logic [17:0] cnt;
  logic [17:0] next_cnt;

  always_comb begin
    if (fire) begin
      next_cnt = COUNT - 18'h00001;
    end else if (cnt != 18'h00000) begin
      next_cnt = cnt - 18'h00001;
    end else begin
      next_cnt = 18'h00000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 18'h00000;
      ready <= 1'b1;
    end else begin
      cnt <= next_cnt;
      ready <= (next_cnt == 18'h00000);
    end
  end
endmodule : dsr_interval_guard

/* hdl/dsr_recorder.sv */
// Dual mode acquisition control: triggered sweeps beside a continuous stream.
// Operation
// - Pre-trigger length zero up to sweep length.
// - Early trigger keeps only captured pre-samples.
// - Trigger delay up to one thousand seconds.
// - Delayed sweep is entirely post-trigger data.
// - At most 200000 sweeps per recording.
// - Sweep triggers accepted at most 400/s.
// - Zero re-arm, one start per 2.5 ms.
// - Stretch restarts post length on new trigger.
// - No stretch when extension overflows memory.
// - At most one stretch per 2.5 ms.
// - Continuous data wins storage arbitration over sweeps; notices and markers go first.
// - Sweep transfer starts right after trigger.
// - Free sweep memory only after full transfer.
// - Transfer sweeps oldest first, in order.
// - Overrun: markers stored, continuous keeps running.
// - New sweep only when full sweep fits.
// - Throttle sweep storage when stream backs up.
// - Continuous FIFO full suspends acquisition.
// - Resume once both memories fully drained.
// - Suspension inserts a notice record.
// - Record until medium full or duration.
`timescale 1ns/1ns
module dsr_recorder #(
  parameter logic [17:0] GAP_CYCLES = 18'(dsr_pkg::MIN_GAP_CYCLES)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [dsr_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  input wire logic trigIn,
  input wire logic sampleValid,
  input wire logic [dsr_pkg::SMP_W-1:0] sampleData,
  input wire logic mediumFull,
  output logic outValid,
  output dsr_pkg::dsr_rec_type outRec,
  input wire logic outReady
);
  import dsr_pkg::*;

  typedef struct packed {
    logic [2:0] trigSync;
    logic trigLevel;
    logic runBit;
    logic stretchEn;
    logic delayEn;
    logic durEn;
    logic [10:0] sweepLen;
    logic [10:0] preLen;
    logic [29:0] delayUs;
    logic [31:0] durUs;
    logic recStop;
    logic suspended;
    logic overrun;
    logic notePend;
    logic [3:0] markPend;
    logic [17:0] sweepCount;
    logic [15:0] markTotal;
    logic [6:0] usPre;
    logic [31:0] elapsedUs;
    logic [29:0] delayCnt;
    dsr_phase_type phase;
    logic [SW_PW-1:0] wrPtr;
    logic [SW_PW-1:0] preStart;
    logic [10:0] preFill;
    logic [10:0] postLeft;
    logic [1:0] qHead;
    logic [1:0] qTail;
    logic [2:0] qCount;
    logic [SW_PW-1:0] rdPtr;
    logic headOpen;
    logic [CF_PW-1:0] cwr;
    logic [CF_PW-1:0] crd;
    logic throttle;
    logic outValid;
    dsr_rec_type outRec;
    logic [31:0] rdData;
  } dsr_state_type;

  dsr_state_type s;
  dsr_state_type n;
  logic [SMP_W-1:0] swMem [0:(1<<SW_AW)-1];
  logic [SMP_W-1:0] cfMem [0:(1<<CF_AW)-1];
  dsr_span_type spanQ [0:3];
  logic startReady;
  logic stretchReady;
  logic startFire;
  logic stretchFire;
  logic swWe;
  logic cfWe;
  logic qPush;
  logic qClose;
  logic [SW_PW-1:0] pushStart;

  function automatic logic roomFor(input logic [10:0] used, input logic [10:0] need);
    roomFor = (SW_DEPTH - used) >= need;
  endfunction : roomFor

  dsr_interval_guard #(.COUNT(GAP_CYCLES)) startGuard (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fire(startFire),
    .ready(startReady)
  );

  dsr_interval_guard #(.COUNT(GAP_CYCLES)) stretchGuard (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fire(stretchFire),
    .ready(stretchReady)
  );

  always_comb begin
    logic trigEv;
    logic recActive;
    logic usTick;
    logic [10:0] preEff;
    logic [10:0] postLen;
    logic [10:0] used;
    logic [10:0] pl;
    logic [SW_PW-1:0] freePtr;
    logic [SW_PW-1:0] limit;
    logic [CF_PW-1:0] cLevel;
    logic headLive;
    logic smpOk;
    logic swAllow;
    logic slot;
    logic markSent;
    logic markNew;
    logic armReset;
    trigEv = 1'b0;
    recActive = 1'b0;
    usTick = 1'b0;
    preEff = 11'h000;
    postLen = 11'h000;
    used = 11'h000;
    pl = 11'h000;
    freePtr = '0;
    limit = '0;
    cLevel = '0;
    headLive = 1'b0;
    smpOk = 1'b0;
    swAllow = 1'b0;
    slot = 1'b0;
    markSent = 1'b0;
    markNew = 1'b0;
    armReset = 1'b0;
    n = s;
    startFire = 1'b0;
    stretchFire = 1'b0;
    swWe = 1'b0;
    cfWe = 1'b0;
    qPush = 1'b0;
    qClose = 1'b0;
    pushStart = s.wrPtr;

    // The first synchroniser stage feeds only the second one.
    n.trigSync = {s.trigSync[1:0], trigIn};
    if (s.trigSync[1] == s.trigSync[2]) begin
      n.trigLevel = s.trigSync[2];
    end
    trigEv = n.trigLevel & ~s.trigLevel;

    usTick = (s.usPre == US_LAST);
    n.usPre = usTick ? 7'h00 : s.usPre + 7'h01;
    recActive = s.runBit & ~s.recStop;
    preEff = (s.preLen > s.sweepLen) ? s.sweepLen : s.preLen;
    postLen = s.sweepLen - preEff;

    if (recActive && usTick) begin
      n.elapsedUs = s.elapsedUs + 32'h00000001;
    end
    if (recActive && (mediumFull || (s.durEn && s.elapsedUs >= s.durUs))) begin
      n.recStop = 1'b1;
    end

    n.rdData = 32'h00000000;
    if (rdStb) begin
      case (addr)
        OFS_CTRL: n.rdData = {28'h0000000, s.durEn, s.delayEn, s.stretchEn, s.runBit};
        OFS_SWEEP_LEN: n.rdData = {21'h000000, s.sweepLen};
        OFS_PRE_LEN: n.rdData = {21'h000000, s.preLen};
        OFS_DELAY: n.rdData = {2'h0, s.delayUs};
        OFS_DURATION: n.rdData = s.durUs;
        OFS_STATUS: n.rdData = {26'h0000000, s.qCount == 3'h0, s.cwr == s.crd,
                                s.overrun, s.suspended, s.phase == PH_POST, recActive};
        OFS_SWEEP_CNT: n.rdData = {14'h0000, s.sweepCount};
        OFS_MARK_CNT: n.rdData = {16'h0000, s.markTotal};
        default: n.rdData = 32'h00000000;
      endcase
    end
    if (wrStb) begin
      case (addr)
        OFS_CTRL: begin
          n.runBit = wrData[CTRL_RUN];
          n.stretchEn = wrData[CTRL_STRETCH];
          n.delayEn = wrData[CTRL_DELAY];
          n.durEn = wrData[CTRL_DURATION];
          if (wrData[CTRL_RUN] && !s.runBit) begin
            n.recStop = 1'b0;
            n.elapsedUs = 32'h00000000;
            n.sweepCount = 18'h00000;
            n.overrun = 1'b0;
          end
        end
        OFS_SWEEP_LEN: begin
          n.sweepLen = (wrData[10:0] > SW_DEPTH || wrData[31:11] != 21'h000000) ? SW_DEPTH : wrData[10:0];
        end
        OFS_PRE_LEN: n.preLen = (wrData[31:11] != 21'h000000) ? SW_DEPTH : wrData[10:0];
        OFS_DELAY: n.delayUs = (wrData[29:0] > DELAY_MAX_US || wrData[31:30] != 2'h0) ? DELAY_MAX_US : wrData[29:0];
        OFS_DURATION: n.durUs = wrData;
        default: n.durUs = s.durUs;
      endcase
    end

    // Continuous FIFO; a sample that finds it full is lost and suspends recording.
    cLevel = s.cwr - s.crd;
    if (recActive && sampleValid && !s.suspended) begin
      if (cLevel == CF_DEPTH) begin
        n.suspended = 1'b1;
      end else begin
        cfWe = 1'b1;
        n.cwr = s.cwr + 7'h01;
        smpOk = 1'b1;
      end
    end

    freePtr = (s.qCount != 3'h0) ? spanQ[s.qHead].start : s.preStart;
    used = s.wrPtr - freePtr;

    case (s.phase)
      PH_IDLE: begin
        armReset = recActive;
      end
      PH_ARM: begin
        if (!recActive || s.suspended) begin
          armReset = 1'b1;
        end else if (trigEv) begin
          if (s.sweepCount < MAX_SWEEPS && startReady) begin
            startFire = 1'b1;
            if (!roomFor(used, s.sweepLen - s.preFill) || s.qCount == Q_DEPTH) begin
              n.overrun = 1'b1;
              markNew = 1'b1;
            end else if (s.delayEn) begin
              n.phase = PH_DELAY;
              n.delayCnt = s.delayUs;
              n.preStart = s.wrPtr;
              n.preFill = 11'h000;
            end else begin
              qPush = 1'b1;
              pushStart = s.preStart;
              n.postLeft = postLen;
              n.phase = PH_POST;
              n.sweepCount = s.sweepCount + 18'h00001;
              n.overrun = 1'b0;
            end
          end
        end else if (smpOk && preEff != 11'h000 && used < SW_DEPTH) begin
          swWe = 1'b1;
          n.wrPtr = s.wrPtr + 11'h001;
          if (s.preFill < preEff) begin
            n.preFill = s.preFill + 11'h001;
          end else begin
            n.preStart = s.preStart + 11'h001;
          end
        end else if (preEff == 11'h000) begin
          n.preStart = s.wrPtr;
          n.preFill = 11'h000;
        end
      end
      PH_DELAY: begin
        if (!recActive || s.suspended) begin
          armReset = 1'b1;
        end else if (s.delayCnt == 30'h00000000) begin
          if (roomFor(used, s.sweepLen) && s.qCount != Q_DEPTH) begin
            qPush = 1'b1;
            n.postLeft = s.sweepLen;
            n.phase = PH_POST;
            n.sweepCount = s.sweepCount + 18'h00001;
            n.overrun = 1'b0;
          end else begin
            n.overrun = 1'b1;
            markNew = 1'b1;
            armReset = 1'b1;
          end
        end else if (usTick) begin
          n.delayCnt = s.delayCnt - 30'h00000001;
        end
      end
      PH_POST: begin
        pl = s.postLeft;
        if (trigEv && s.stretchEn && stretchReady && roomFor(used, postLen)) begin
          pl = postLen;
          stretchFire = 1'b1;
        end
        if (!recActive || s.suspended || pl == 11'h000) begin
          qClose = 1'b1;
          armReset = 1'b1;
        end else if (smpOk) begin
          swWe = 1'b1;
          n.wrPtr = s.wrPtr + 11'h001;
          n.postLeft = pl - 11'h001;
        end else begin
          n.postLeft = pl;
        end
      end
      default: armReset = 1'b1;
    endcase
    if (armReset) begin
      n.phase = recActive ? PH_ARM : PH_IDLE;
      n.preStart = s.wrPtr;
      n.preFill = 11'h000;
    end

    // While a sweep is still being captured the reader may follow the write pointer.
    headLive = (s.qCount == 3'h1) && (s.phase == PH_POST);
    limit = headLive ? s.wrPtr : spanQ[s.qHead].stop;
    if (cLevel >= CF_3Q) begin
      swAllow = 1'b0;
    end else if (cLevel >= CF_HALF) begin
      swAllow = s.throttle;
      n.throttle = ~s.throttle;
    end else begin
      swAllow = 1'b1;
    end

    slot = ~s.outValid | outReady;
    if (slot) begin
      n.outValid = 1'b0;
    end
    if (slot && s.notePend) begin
      n.outValid = 1'b1;
      n.outRec = '{kind: K_NOTE, data: s.markTotal};
      n.notePend = 1'b0;
    end else if (slot && s.markPend != 4'h0) begin
      n.outValid = 1'b1;
      n.outRec = '{kind: K_MARK, data: s.markTotal};
      markSent = 1'b1;
    end else if (slot && s.cwr != s.crd) begin
      n.outValid = 1'b1;
      n.outRec = '{kind: K_CONT, data: cfMem[s.crd[CF_AW-1:0]]};
      n.crd = s.crd + 7'h01;
    end else if (s.qCount != 3'h0) begin
      if (!s.headOpen) begin
        n.rdPtr = spanQ[s.qHead].start;
        n.headOpen = 1'b1;
      end else if (s.rdPtr == limit && !headLive) begin
        n.qHead = s.qHead + 2'h1;
        n.headOpen = 1'b0;
      end else if (slot && swAllow && s.rdPtr != limit) begin
        n.outValid = 1'b1;
        n.outRec = '{kind: K_SWEEP, data: swMem[s.rdPtr[SW_AW-1:0]]};
        n.rdPtr = s.rdPtr + 11'h001;
      end
    end

    if (s.suspended && s.cwr == s.crd && s.qCount == 3'h0) begin
      n.suspended = 1'b0;
    end
    if (n.suspended && !s.suspended) begin
      n.notePend = 1'b1;
    end
    if (qPush) begin
      n.qTail = s.qTail + 2'h1;
    end
    n.qCount = s.qCount + {2'h0, qPush} - {2'h0, n.qHead != s.qHead};
    if (markNew) begin
      n.markTotal = s.markTotal + 16'h0001;
    end
    // A new marker in the cycle one leaves keeps the pending count unchanged.
    if (markNew && !markSent && s.markPend != 4'hF) begin
      n.markPend = s.markPend + 4'h1;
    end else if (markSent && !markNew) begin
      n.markPend = s.markPend - 4'h1;
    end
  end

  // Memories carry no reset; nothing reads a word before it has been written.
  always_ff @(posedge core_clk) begin
    if (swWe) begin
      swMem[s.wrPtr[SW_AW-1:0]] <= sampleData;
    end
    if (cfWe) begin
      cfMem[s.cwr[CF_AW-1:0]] <= sampleData;
    end
    if (qPush) begin
      spanQ[s.qTail] <= '{start: pushStart, stop: pushStart};
    end
    if (qClose) begin
      spanQ[s.qTail - 2'h1].stop <= s.wrPtr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.sweepLen <= SWEEP_LEN_RST;
      s.preLen <= PRE_LEN_RST;
    end else begin
      s <= n;
    end
  end

  assign rdData = s.rdData;
  assign outValid = s.outValid;
  assign outRec = s.outRec;
endmodule : dsr_recorder

/* tb/dsr_storage_model.sv */
// Storage host model that accepts records promptly, at random, or not at all.
`timescale 1ns/1ns
module dsr_storage_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  output logic outReady
);
  // Mode 0 always accepts, mode 1 stalls at random, mode 2 stalls until told otherwise.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outReady <= 1'b0;
    end else begin
      outReady <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(1, 0) == 1);
    end
  end
endmodule : dsr_storage_model

/* tb/dsr_recorder_sva.sv */
// Port checker for the dual sweep and continuous recorder.
`timescale 1ns/1ns
module dsr_recorder_sva import dsr_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [dsr_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [31:0] rdData,
  input wire logic outValid,
  input wire dsr_pkg::dsr_rec_type outRec,
  input wire logic outReady
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic runEver;
  // Nothing may reach storage before software has started a recording once.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      runEver <= 1'b0;
    end else if (wrStb && addr == OFS_CTRL && wrData[CTRL_RUN]) begin
      runEver <= 1'b1;
    end
  end
  property p_hold;
    outValid && !outReady |=> outValid && $stable(outRec);
  endproperty
  a_hold: assert property (p_hold) else $error("record changed before it was taken");
  property p_fall;
    $fell(outValid) |-> $past(outReady);
  endproperty
  a_fall: assert property (p_fall) else $error("record dropped without acceptance");
  property p_quiet;
    !runEver |-> !outValid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("record sent before any run");
  property p_rd_idle;
    !rdStb |=> rdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_cnt_max;
    rdStb && addr == OFS_SWEEP_CNT |=> rdData <= 32'(MAX_SWEEPS);
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("sweep count beyond limit");
  property p_delay_max;
    rdStb && addr == OFS_DELAY |=> rdData <= 32'(DELAY_MAX_US);
  endproperty
  a_delay_max: assert property (p_delay_max) else $error("delay beyond limit");
  property p_status_hi;
    rdStb && addr == OFS_STATUS |=> rdData[31:6] == 26'h0;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
  property p_mark_hi;
    rdStb && addr == OFS_MARK_CNT |=> rdData[31:16] == 16'h0;
  endproperty
  a_mark_hi: assert property (p_mark_hi) else $error("marker count upper bits set");
  c_sweep: cover property (outValid && outReady && outRec.kind == K_SWEEP);
  c_cont: cover property (outValid && outReady && outRec.kind == K_CONT);
  c_note: cover property (outValid && outReady && outRec.kind == K_NOTE);
  c_mark: cover property (outValid && outReady && outRec.kind == K_MARK);
endmodule : dsr_recorder_sva

bind dsr_recorder dsr_recorder_sva u_sva (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
  .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .outValid(outValid), .outRec(outRec), .outReady(outReady));

/* tb/dsr_recorder_tb.sv */
// Self-checking bench for the dual sweep and continuous recorder.
`timescale 1ns/1ns
module dsr_recorder_tb;
  import dsr_pkg::*;
  logic core_clk, rst_n, wrStb, rdStb, trigIn, sampleValid, mediumFull, outValid, outReady;
  logic [4:0] addr;
  logic [31:0] wrData, rdData, d;
  logic [15:0] sampleData;
  logic [1:0] mode;
  dsr_rec_type outRec;
  int bad_count, n_tests, h, n0;
  int kindCnt [4];
  logic [15:0] hist [$], cq [$], sg [$], eq [$];
  bit keepCont;
  // A short guard interval keeps the rate limits testable in a few hundred cycles.
  dsr_recorder #(.GAP_CYCLES(18'h00032)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .trigIn(trigIn),
    .sampleValid(sampleValid), .sampleData(sampleData), .mediumFull(mediumFull), .outValid(outValid),
    .outRec(outRec), .outReady(outReady));
  dsr_storage_model u_host (.core_clk(core_clk), .rst_n(rst_n), .mode(mode), .outReady(outReady));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wrData <= v;
    wrStb <= 1'b1;
    @(posedge core_clk);
    wrStb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are taken at the edge that ends that cycle.
  task automatic rd(input logic [4:0] a);
    @(posedge core_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    @(posedge core_clk);
    d = rdData;
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string name);
    rd(a);
    check(name, e, d);
  endtask : rdc
  task automatic sbit(input int b, input logic e);
    rd(OFS_STATUS);
    check("status bit", 32'(e), 32'(d[b]));
  endtask : sbit
  task automatic samp(input int n);
    logic [15:0] v;
    repeat (n) begin
      v = 16'($urandom);
      @(posedge core_clk);
      sampleValid <= 1'b1;
      sampleData <= v;
      hist.push_back(v);
      if (keepCont) cq.push_back(v);
      @(posedge core_clk);
      sampleValid <= 1'b0;
    end
  endtask : samp
  task automatic trig;
    @(posedge core_clk);
    trigIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    trigIn <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : trig
  task automatic push(input int first, input int n);
    for (int i = 0; i < n; i++) eq.push_back(hist[first + i]);
  endtask : push
  task automatic chk_sweep;
    repeat (150) @(posedge core_clk);
    check("sweep words", 32'(eq.size()), 32'(sg.size()));
    foreach (eq[i]) if (i < sg.size()) check("sweep data", 32'(eq[i]), 32'(sg[i]));
    eq.delete();
    sg.delete();
  endtask : chk_sweep
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Values are sampled at the edge, before the edge's own updates land.
  always @(posedge core_clk) begin
    if (rst_n === 1'b1 && outValid === 1'b1 && outReady === 1'b1) begin
      kindCnt[outRec.kind]++;
      if (outRec.kind == K_SWEEP) sg.push_back(outRec.data);
      if (outRec.kind == K_CONT && cq.size() > 0) check("cont data", 32'(cq.pop_front()), 32'(outRec.data));
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    addr = 5'h00;
    wrData = 32'h0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    trigIn = 1'b0;
    sampleValid = 1'b0;
    sampleData = 16'h0;
    mediumFull = 1'b0;
    mode = 2'h2;
    void'($urandom(16250));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(OFS_CTRL, 32'h0, "ctrl reset");
    rdc(OFS_SWEEP_LEN, 32'h400, "sweep len reset");
    rdc(OFS_PRE_LEN, 32'h0, "pre len reset");
    rdc(5'h02, 32'h0, "unmapped");
    wr(OFS_SWEEP_CNT, 32'h55);
    rdc(OFS_SWEEP_CNT, 32'h0, "read only count");
    wr(OFS_DELAY, 32'hFFFFFFFF);
    rdc(OFS_DELAY, 32'(DELAY_MAX_US), "delay clamp");
    wr(OFS_PRE_LEN, 32'h400);
    rdc(OFS_PRE_LEN, 32'h400, "full pre len");
    $display("Test registers done");
    wr(OFS_SWEEP_LEN, 32'h8);
    wr(OFS_PRE_LEN, 32'h4);
    wr(OFS_DELAY, 32'h1);
    keepCont = 1'b1;
    wr(OFS_CTRL, 32'h1);
    samp(2);
    h = hist.size();
    trig;
    samp(4);
    push(h - 2, 6);
    repeat (60) @(posedge core_clk);
    samp(6);
    h = hist.size();
    trig;
    samp(4);
    push(h - 4, 8);
    trig;
    samp(4);
    mode <= 2'h1;
    chk_sweep;
    rdc(OFS_SWEEP_CNT, 32'h2, "sweep count");
    $display("Test sweeps done");
    wr(OFS_CTRL, 32'h5);
    trig;
    repeat (250) @(posedge core_clk);
    h = hist.size();
    samp(8);
    push(h, 8);
    chk_sweep;
    $display("Test delay done");
    wr(OFS_CTRL, 32'h3);
    samp(4);
    h = hist.size();
    trig;
    samp(2);
    trig;
    samp(2);
    trig;
    samp(4);
    push(h - 4, 10);
    chk_sweep;
    $display("Test stretch done");
    wr(OFS_CTRL, 32'h1);
    wr(OFS_PRE_LEN, 32'h0);
    mode <= 2'h2;
    h = hist.size();
    repeat (5) begin
      trig;
      samp(8);
      repeat (40) @(posedge core_clk);
    end
    // Four stalled sweeps fill the span queue, so the fifth trigger only leaves a marker.
    rdc(OFS_MARK_CNT, 32'h1, "marker total");
    sbit(ST_OVERRUN, 1'b1);
    rdc(OFS_SWEEP_CNT, 32'h8, "count after overrun");
    mode <= 2'h0;
    push(h, 32);
    chk_sweep;
    check("marker sent", 32'h1, 32'(kindCnt[K_MARK]));
    $display("Test overrun done");
    keepCont = 1'b0;
    mode <= 2'h2;
    n0 = kindCnt[K_NOTE];
    samp(70);
    sbit(ST_SUSPENDED, 1'b1);
    mode <= 2'h0;
    repeat (300) @(posedge core_clk);
    check("notice count", 32'(n0 + 1), 32'(kindCnt[K_NOTE]));
    sbit(ST_SUSPENDED, 1'b0);
    $display("Test suspend done");
    mediumFull <= 1'b1;
    repeat (5) @(posedge core_clk);
    n0 = kindCnt[K_CONT];
    samp(4);
    repeat (20) @(posedge core_clk);
    check("cont after full", 32'(n0), 32'(kindCnt[K_CONT]));
    sbit(ST_RECORDING, 1'b0);
    $display("Test medium full done");
    complete_run();
  end
endmodule : dsr_recorder_tb
